// file: design/iscg_pkg.sv
/*
  Package for the idle/stop clock gating controller: register addresses,
  field positions, reset values, state encoding and carrier structs.
  Assumes an 8-bit special function register port driven by the CPU core.
*/
package iscg_pkg;

  // ==========================================================================
  // Register addresses.
  // ==========================================================================
  localparam logic [7:0] ISCG_ADDR_POWER_CTRL  = 8'h87;
  localparam logic [7:0] ISCG_ADDR_ACT_OVR     = 8'hf5;
  localparam logic [7:0] ISCG_ADDR_CLOCK_MODE  = 8'hfd;
  localparam logic [7:0] ISCG_ADDR_IDLE_GATE   = 8'hfe;

  // ==========================================================================
  // Field positions and reset values.
  // ==========================================================================
  localparam int         ISCG_POS_IDLE_SEL     = 0;
  localparam int         ISCG_POS_STOP_SEL     = 1;
  localparam int         ISCG_POS_LPM_EN       = 2;
  localparam int         ISCG_NUM_GROUPS       = 4;
  localparam logic [7:0] ISCG_RST_POWER_CTRL   = 8'h00;
  localparam logic [3:0] ISCG_RST_ACT_OVR      = 4'h0;
  localparam logic [3:0] ISCG_RST_IDLE_GATE    = 4'h0;
  localparam logic       ISCG_RST_LPM_EN       = 1'b0;
  localparam logic [15:0] ISCG_RESET_VECTOR    = 16'h0000;

  // Group index: 3 rtc/pulse/pmu, 2 timers/crc, 1 adc/pca, 0 uart/t3/spi/smbus.
  localparam int         ISCG_GRP_RTC_PMU      = 3;
  localparam int         ISCG_GRP_TIMER_CRC    = 2;
  localparam int         ISCG_GRP_ADC_PCA      = 1;
  localparam int         ISCG_GRP_SERIAL       = 0;

  // ==========================================================================
  // Types.
  // ==========================================================================
  typedef enum logic [1:0] {
    ISCG_RUN  = 2'b00,
    ISCG_IDLE = 2'b01,
    ISCG_STOP = 2'b11
  } iscg_mode_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iscg_sfr_req_t;

  typedef struct packed {
    logic       insn_done;
    logic       irq_pending;
    logic       wdt_reset;
    logic       mcd_reset;
    logic       ext_reset;
  } iscg_cpu_evt_t;

endpackage : iscg_pkg

// file: design/iscg_ctrl.sv
/*
  Idle and stop mode sequencing plus low power clock gating for the CPU
  and four peripheral clock groups.
  Assumes the CPU core presents register accesses on one clock, flags the
  retirement of each instruction, and ends every access with insn_done.
*/
// Contract
// RULE1 - Idle starts after setting instruction completes
// RULE2 - Idle keeps registers; peripherals keep running
// RULE3 - Enabled interrupt clears idle, resumes CPU
// RULE4 - Return resumes after idle setting instruction
// RULE5 - Reset ends idle, fetch from zero
// RULE6 - Watchdog expiry reset ends idle
// RULE7 - Stop starts after setting instruction completes
// RULE8 - Stop halts CPU and precision oscillator
// RULE9 - Only reset ends stop, not interrupts
// RULE10 - Missing clock reset ends stop mode
// RULE11 - Low power enable gates CPU in idle
// RULE12 - Low power idle gates by gate register
// RULE13 - Active low power gates peripherals, never CPU
// RULE14 - Override one forces group clock on
// RULE15 - Override bit 3: rtc, pulse, pmu
// RULE16 - Override bit 2: timers, crc
// RULE17 - Override bit 1: adc, pca
// RULE18 - Override bit 0: uart, timer3, spi, smbus
// RULE19 - Override upper bits read zero, reset zero
// RULE20 - Gate bits enable groups in low power idle
// RULE21 - Enable at bit 2 of clock mode
// RULE22 - Gates change only while clock low
`timescale 1ns/1ns
module iscg_ctrl
  import iscg_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire iscg_sfr_req_t              sfr_req,
  output logic [7:0]                      sfr_rdata,
  input  wire iscg_cpu_evt_t              cpu_evt,
  output logic                            cpu_halt,
  output logic                            cpu_restart,
  output logic [15:0]                     restart_vector,
  output logic                            precision_osc_en,
  output iscg_mode_t                      mode,
  output logic                            cpu_clk,
  output logic [ISCG_NUM_GROUPS-1:0]      periph_clk
);

  // ==========================================================================
  // Registers.
  // ==========================================================================
  iscg_mode_t                 mode_r;
  iscg_mode_t                 mode_nxt;
  logic                       idle_sel_r;
  logic                       stop_sel_r;
  logic                       pend_idle_r;
  logic                       pend_stop_r;
  logic [3:0]                 act_ovr_r;
  logic [3:0]                 idle_gate_r;
  logic                       lpm_en_r;
  logic                       any_reset;
  logic                       cpu_en;
  logic [ISCG_NUM_GROUPS-1:0] grp_en;
  logic                       cpu_en_lat;
  logic [ISCG_NUM_GROUPS-1:0] grp_en_lat;

  function automatic logic hit(input iscg_sfr_req_t r, input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction : hit

  assign any_reset = cpu_evt.wdt_reset || cpu_evt.mcd_reset || cpu_evt.ext_reset;

  // ==========================================================================
  // Software-written configuration.
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (reset || any_reset) begin
      act_ovr_r   <= ISCG_RST_ACT_OVR; // RULE19
      idle_gate_r <= ISCG_RST_IDLE_GATE;
      lpm_en_r    <= ISCG_RST_LPM_EN;
    end else begin
      if (hit(sfr_req, ISCG_ADDR_ACT_OVR)) begin
        act_ovr_r <= sfr_req.wdata[3:0]; // RULE19
      end
      if (hit(sfr_req, ISCG_ADDR_IDLE_GATE)) begin
        idle_gate_r <= sfr_req.wdata[3:0];
      end
      if (hit(sfr_req, ISCG_ADDR_CLOCK_MODE)) begin
        lpm_en_r <= sfr_req.wdata[ISCG_POS_LPM_EN]; // RULE21
      end
    end
  end

  // ==========================================================================
  // Mode select bits: written now, acted on when the instruction retires.
  // ==========================================================================
  // A write in the cycle in which the previous instruction retires belongs to
  // the next instruction, so the write wins over the retirement clear.
  always_ff @(posedge clk) begin
    if (reset || any_reset) begin
      pend_idle_r <= 1'b0;
      pend_stop_r <= 1'b0;
    end else if (hit(sfr_req, ISCG_ADDR_POWER_CTRL)) begin
      pend_idle_r <= sfr_req.wdata[ISCG_POS_IDLE_SEL];
      pend_stop_r <= sfr_req.wdata[ISCG_POS_STOP_SEL];
    end else if (cpu_evt.insn_done) begin
      pend_idle_r <= 1'b0;
      pend_stop_r <= 1'b0;
    end
  end

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      ISCG_RUN: begin
        if (cpu_evt.insn_done && pend_stop_r) begin
          mode_nxt = ISCG_STOP; // RULE7
        end else if (cpu_evt.insn_done && pend_idle_r) begin
          mode_nxt = ISCG_IDLE; // RULE1
        end
      end
      ISCG_IDLE: begin
        if (cpu_evt.irq_pending) begin
          mode_nxt = ISCG_RUN; // RULE3
        end
      end
      ISCG_STOP: begin
        mode_nxt = ISCG_STOP; // RULE9
      end
      default: begin
        mode_nxt = ISCG_RUN;
      end
    endcase
  end

  // Any reset returns to run; watchdog and missing clock act the same way.
  always_ff @(posedge clk) begin
    if (reset || any_reset) begin
      mode_r <= ISCG_RUN; // RULE5 RULE6 RULE10
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || any_reset) begin
      idle_sel_r <= 1'b0;
      stop_sel_r <= 1'b0;
    end else begin
      idle_sel_r <= (mode_nxt == ISCG_IDLE); // RULE3
      stop_sel_r <= (mode_nxt == ISCG_STOP);
    end
  end

  // Restart strobe tells the core to run its reset sequence from zero.
  always_ff @(posedge clk) begin
    if (reset) begin
      cpu_restart <= 1'b0;
    end else begin
      cpu_restart <= any_reset; // RULE5 RULE9
    end
  end

  assign restart_vector = ISCG_RESET_VECTOR; // RULE5 RULE9

  // The core only stalls its fetch; its program counter is untouched, so the
  // interrupt return lands on the instruction after the setting one.
  assign cpu_halt         = (mode_r != ISCG_RUN); // RULE2 RULE4 RULE8
  assign precision_osc_en = (mode_r != ISCG_STOP); // RULE8
  assign mode             = mode_r;

  always_comb begin
    sfr_rdata = 8'h00;
    if (sfr_req.rd && sfr_req.addr == ISCG_ADDR_POWER_CTRL) begin
      sfr_rdata = {6'h00, stop_sel_r, idle_sel_r};
    end else if (sfr_req.rd && sfr_req.addr == ISCG_ADDR_ACT_OVR) begin
      sfr_rdata = {4'h0, act_ovr_r}; // RULE19
    end else if (sfr_req.rd && sfr_req.addr == ISCG_ADDR_CLOCK_MODE) begin
      sfr_rdata = {5'h00, lpm_en_r, 2'b00};
    end else if (sfr_req.rd && sfr_req.addr == ISCG_ADDR_IDLE_GATE) begin
      sfr_rdata = {4'h0, idle_gate_r};
    end
  end

  // ==========================================================================
  // Clock enables and glitch-free gates.
  // ==========================================================================
  // Plain idle leaves peripherals running; the CPU clock stops in any idle.
  assign cpu_en = (mode_r == ISCG_RUN); // RULE11 RULE13

  generate
    for (genvar g = 0; g < ISCG_NUM_GROUPS; g++) begin : g_grp
      // Group order: 3 rtc/pulse/pmu, 2 timers/crc, 1 adc/pca, 0 serial.
      always_comb begin
        if (!lpm_en_r) begin
          grp_en[g] = (mode_r != ISCG_STOP); // RULE2
        end else if (mode_r == ISCG_IDLE) begin
          grp_en[g] = idle_gate_r[g]; // RULE12 RULE20
        end else if (mode_r == ISCG_RUN) begin
          grp_en[g] = act_ovr_r[g] || idle_gate_r[g]; // RULE14 RULE15 RULE16 RULE17 RULE18
        end else begin
          grp_en[g] = 1'b0;
        end
      end
    end
  endgenerate

  // Latch enables while the clock is low so no runt pulse escapes.
  always_latch begin
    if (!clk) begin
      cpu_en_lat <= cpu_en; // RULE22
      grp_en_lat <= grp_en; // RULE22
    end
  end

  assign cpu_clk    = clk & cpu_en_lat;
  assign periph_clk = {ISCG_NUM_GROUPS{clk}} & grp_en_lat;

  // ==========================================================================
  // Checks.
  // ==========================================================================
  sequence s_idle_armed;
    pend_idle_r && !pend_stop_r && cpu_evt.insn_done && mode_r == ISCG_RUN;
  endsequence

  chk_idle_after_done: assert property (@(posedge clk) disable iff (reset || any_reset)
    s_idle_armed |=> mode_r == ISCG_IDLE && cpu_halt) // RULE1
    else $error("idle not entered after retiring instruction");
  chk_stop_after_done: assert property (@(posedge clk) disable iff (reset || any_reset)
    pend_stop_r && cpu_evt.insn_done |=> mode_r == ISCG_STOP && !precision_osc_en) // RULE7
    else $error("stop not entered after retiring instruction");
  chk_irq_wakes_idle: assert property (@(posedge clk) disable iff (reset || any_reset)
    mode_r == ISCG_IDLE && cpu_evt.irq_pending |=> !idle_sel_r && !cpu_halt) // RULE3
    else $error("interrupt did not end idle");
  chk_stop_ignores_irq: assert property (@(posedge clk) disable iff (reset || any_reset)
    mode_r == ISCG_STOP && cpu_evt.irq_pending |=> mode_r == ISCG_STOP) // RULE9
    else $error("interrupt ended stop");
  chk_reset_restarts: assert property (@(posedge clk) disable iff (reset)
    any_reset |=> mode_r == ISCG_RUN && cpu_restart && restart_vector == 16'h0000) // RULE5
    else $error("reset did not restart from zero");
  chk_wdt_ends_idle: assert property (@(posedge clk) disable iff (reset)
    mode_r == ISCG_IDLE && cpu_evt.wdt_reset |=> !cpu_halt) // RULE6
    else $error("watchdog did not end idle");
  chk_mcd_ends_stop: assert property (@(posedge clk) disable iff (reset)
    mode_r == ISCG_STOP && cpu_evt.mcd_reset |=> precision_osc_en) // RULE10
    else $error("missing clock reset did not end stop");
  chk_cpu_gated_idle: assert property (@(posedge clk) disable iff (reset)
    lpm_en_r && mode_r == ISCG_IDLE |-> !cpu_en) // RULE11
    else $error("cpu clock enabled in low power idle");
  chk_active_cpu_on: assert property (@(posedge clk) disable iff (reset)
    lpm_en_r && mode_r == ISCG_RUN |-> cpu_en) // RULE13
    else $error("cpu clock gated in low power active");
  chk_override_forces: assert property (@(posedge clk) disable iff (reset)
    lpm_en_r && mode_r == ISCG_RUN |-> (grp_en & act_ovr_r) == act_ovr_r) // RULE14
    else $error("override did not force group clock");
  chk_idle_gate_map: assert property (@(posedge clk) disable iff (reset)
    lpm_en_r && mode_r == ISCG_IDLE |-> grp_en == idle_gate_r) // RULE12
    else $error("idle gating differs from gate register");
  chk_ovr_upper_zero: assert property (@(posedge clk) disable iff (reset)
    sfr_req.rd && sfr_req.addr == ISCG_ADDR_ACT_OVR |-> sfr_rdata[7:4] == 4'h0) // RULE19
    else $error("override upper bits not zero");

endmodule : iscg_ctrl

// file: test/iscg_cpu_model.sv
/*
  CPU core model: drives register accesses, instruction retirement,
  interrupt level and the three reset pulses into the clock controller.
  Assumes the controller samples every input on the rising edge of clk.
*/
`timescale 1ns/1ns
module iscg_cpu_model
  import iscg_pkg::*;
(
  input  wire logic clk,
  output iscg_sfr_req_t sfr_req,
  output iscg_cpu_evt_t cpu_evt
);
  // ==========================================================================
  // Bus and event drivers, all changing just after a falling edge.
  // ==========================================================================
  initial begin
    sfr_req = '0;
    cpu_evt = '0;
  end

  // A released bus shows inverted address and data so stale values never match.
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata);
    @(negedge clk);
    sfr_req = '{wr, !wr, addr, wdata};
    @(negedge clk);
    sfr_req = '{1'b0, 1'b0, ~addr, ~wdata};
  endtask : access

  // One-cycle event pulse; the interrupt level is kept as it was.
  task automatic pulse(input iscg_cpu_evt_t e, input int gap);
    repeat (gap) @(negedge clk);
    @(negedge clk);
    e.irq_pending = cpu_evt.irq_pending;
    cpu_evt = e;
    @(negedge clk);
    e = '0;
    e.irq_pending = cpu_evt.irq_pending;
    cpu_evt = e;
  endtask : pulse

  task automatic irq(input logic v);
    @(negedge clk);
    cpu_evt.irq_pending = v;
  endtask : irq
endmodule : iscg_cpu_model

// file: test/iscg_ctrl_tb.sv
/*
  Self-checking testbench for the idle/stop clock gating controller.
  Assumes the CPU core model in iscg_cpu_model and the package constants.
*/
`timescale 1ns/1ns
module iscg_ctrl_tb;
  import iscg_pkg::*;
  logic                 clk = 1'b0;
  logic                 reset = 1'b1;
  iscg_sfr_req_t        sfr_req;
  iscg_cpu_evt_t        cpu_evt;
  logic [7:0]           sfr_rdata, d;
  logic                 cpu_halt, cpu_restart, precision_osc_en, cpu_clk;
  logic [15:0]          restart_vector;
  iscg_mode_t           mode;
  logic [3:0]           periph_clk, ovr;
  logic [7:0]           exp_q[$];
  int                   n_errors = 0, checked = 0, restarts = 0, seed = 21, r0;
  logic [7:0]           sel[4] = '{8'h01, 8'h02, 8'h01, 8'h02};
  logic [4:0]           rst_ev[4] = '{5'h04, 5'h02, 5'h01, 5'h01};

  always #4 clk = ~clk;

  iscg_cpu_model u_iscg_cpu_model (.clk(clk), .sfr_req(sfr_req), .cpu_evt(cpu_evt));
  iscg_ctrl u_iscg_ctrl (.clk(clk), .reset(reset), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .cpu_evt(cpu_evt), .cpu_halt(cpu_halt), .cpu_restart(cpu_restart),
    .restart_vector(restart_vector), .precision_osc_en(precision_osc_en), .mode(mode),
    .cpu_clk(cpu_clk), .periph_clk(periph_clk));

  // ==========================================================================
  // Checking tasks and monitors.
  // ==========================================================================
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("Counts: %0d checks, %0d mismatches", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  always @(posedge clk) begin
    if (sfr_req.rd === 1'b1) check(16'(sfr_rdata), 16'(exp_q.pop_front()));
    if (cpu_restart === 1'b1) restarts++;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    u_iscg_cpu_model.access(1'b1, a, v);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_iscg_cpu_model.access(1'b0, a, 8'h00);
  endtask : rd

  // Gated clocks must be high with clk only where enabled, and low while clk is low.
  task automatic clks(input logic c, input logic [3:0] g);
    @(posedge clk);
    #2;
    check(16'({cpu_clk, periph_clk}), 16'({c, g}));
    @(negedge clk);
    #1;
    check(16'({cpu_clk, periph_clk}), 16'h0000);
  endtask : clks

  task automatic mode_is(input iscg_mode_t m, input logic h);
    check(16'(mode), 16'(m));
    check(16'(cpu_halt), 16'(h));
  endtask : mode_is

  initial begin
    #100000;
    n_errors++;
    report_and_stop();
  end

  // ==========================================================================
  // Test sequence.
  // ==========================================================================
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    rd(ISCG_ADDR_ACT_OVR, 8'h00);
    rd(ISCG_ADDR_IDLE_GATE, 8'h00);
    rd(ISCG_ADDR_CLOCK_MODE, 8'h00);
    rd(ISCG_ADDR_POWER_CTRL, 8'h00);
    rd(8'h00, 8'h00);
    clks(1'b1, 4'hf);
    mode_is(ISCG_RUN, 1'b0);
    check(16'(precision_osc_en), 16'h0001);
    $display("Test reset values done");
    wr(ISCG_ADDR_CLOCK_MODE, 8'hff);
    rd(ISCG_ADDR_CLOCK_MODE, 8'h04);
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      wr(ISCG_ADDR_ACT_OVR, d);
      rd(ISCG_ADDR_ACT_OVR, {4'h0, d[3:0]});
      ovr = d[3:0];
      d = 8'($random(seed));
      wr(ISCG_ADDR_IDLE_GATE, d);
      rd(ISCG_ADDR_IDLE_GATE, {4'h0, d[3:0]});
      clks(1'b1, ovr | d[3:0]);
    end
    wr(ISCG_ADDR_CLOCK_MODE, 8'h00);
    clks(1'b1, 4'hf);
    $display("Test active gating done");
    wr(ISCG_ADDR_CLOCK_MODE, 8'h04);
    wr(ISCG_ADDR_IDLE_GATE, 8'h05);
    wr(ISCG_ADDR_POWER_CTRL, 8'h01);
    mode_is(ISCG_RUN, 1'b0);
    u_iscg_cpu_model.pulse(5'h10, 2);
    repeat (2) @(negedge clk);
    mode_is(ISCG_IDLE, 1'b1);
    rd(ISCG_ADDR_POWER_CTRL, 8'h01);
    rd(ISCG_ADDR_IDLE_GATE, 8'h05);
    clks(1'b0, 4'h5);
    r0 = restarts;
    u_iscg_cpu_model.irq(1'b1);
    u_iscg_cpu_model.irq(1'b0);
    repeat (2) @(negedge clk);
    mode_is(ISCG_RUN, 1'b0);
    check(16'(restarts - r0), 16'h0000);
    rd(ISCG_ADDR_POWER_CTRL, 8'h00);
    clks(1'b1, ovr | 4'h5);
    $display("Test low power idle done");
    for (int k = 0; k < 4; k++) begin
      wr(ISCG_ADDR_POWER_CTRL, sel[k]);
      u_iscg_cpu_model.pulse(5'h10, k);
      repeat (2) @(negedge clk);
      mode_is(sel[k][1] ? ISCG_STOP : ISCG_IDLE, 1'b1);
      if (sel[k][1]) begin
        check(16'(precision_osc_en), 16'h0000);
        u_iscg_cpu_model.irq(1'b1);
        repeat (2) @(negedge clk);
        check(16'(mode), 16'(ISCG_STOP));
        u_iscg_cpu_model.irq(1'b0);
      end
      r0 = restarts;
      u_iscg_cpu_model.pulse(rst_ev[k], 0);
      repeat (3) @(negedge clk);
      check(16'(restarts - r0), 16'h0001);
      check(restart_vector, ISCG_RESET_VECTOR);
      mode_is(ISCG_RUN, 1'b0);
      check(16'(precision_osc_en), 16'h0001);
      rd(ISCG_ADDR_CLOCK_MODE, 8'h00);
    end
    $display("Test reset wake-up done");
    wr(ISCG_ADDR_ACT_OVR, 8'h0a);
    wr(ISCG_ADDR_CLOCK_MODE, 8'h04);
    rd(ISCG_ADDR_ACT_OVR, 8'h0a);
    @(negedge clk) reset = 1'b1;
    @(negedge clk) reset = 1'b0;
    rd(ISCG_ADDR_ACT_OVR, 8'h00);
    rd(ISCG_ADDR_CLOCK_MODE, 8'h00);
    clks(1'b1, 4'hf);
    mode_is(ISCG_RUN, 1'b0);
    $display("Test mid-run reset done");
    report_and_stop();
  end
endmodule : iscg_ctrl_tb
